// ===== rtl/lp_pkg.sv
// Operation
// - dormant: logic off, rams kept powered
// - dormant exit: reset pulse, then run
// - shutdown: logic, caches, rams all off
// - shutdown exit: reset pulse, run, software reinits
// - entry via mode write, save, then wait
// - standby asserts wait pipe halted indicator
// - coherent request in standby restarts clock
// - dormant coherent response: miss and dirty
// - shutdown coherent response: miss, no dirty
// - debug access in standby restarts clock
// - core debug access when off errors
// - debug domain registers stay accessible off
// - power-down reported in powerdown status
// - coherency and debug logic always powered
package lp_pkg;
  typedef enum logic [1:0] {
    MODE_RUN,
    MODE_STANDBY,
    MODE_DORMANT,
    MODE_SHUTDOWN
  } pwr_mode_e;
  localparam logic [1:0] REQ_RUN      = 2'h0;
  localparam logic [1:0] REQ_DORMANT  = 2'h2;
  localparam logic [1:0] REQ_SHUTDOWN = 2'h3;
  localparam int         CLK_HZ       = 50000000;
  localparam int         IDLE_NS      = 100;
  localparam int         IDLE_CYC     = (IDLE_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam logic [3:0] IDLE_CNT     = 4'(IDLE_CYC);
  localparam logic [7:0] STATUS_RST   = 8'h00;
  localparam int         ST_PWR_DOWN  = 0;
  localparam int         ST_STICKY_PD = 1;
  localparam int         ST_RESET     = 2;
  localparam int         ST_STICKY_RS = 3;
endpackage

// ===== rtl/lp_sync.sv
module lp_sync
  import lp_pkg::*;
#(
  parameter int W = 1
)
(
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_reg;
  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      meta_reg <= '0;
      q        <= '0;
    end
    else
    begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule

// ===== rtl/lp_clk_req.sv
module lp_clk_req
  import lp_pkg::*;
(
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic standby,
  input  wire logic busy,
  output logic      clk_run
);
  logic [3:0] idle_reg;
  logic [3:0] idle_next;
  // hold clock a few cycles after activity to avoid gating glitches between beats
  assign idle_next = busy ? IDLE_CNT : ((idle_reg != 4'h0) ? idle_reg - 4'h1 : 4'h0);
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      idle_reg <= IDLE_CNT;
      clk_run  <= 1'b1;
    end
    else
    begin
      idle_reg <= idle_next;
      clk_run  <= !standby || busy || (idle_next != 4'h0);
    end
  end
endmodule

// ===== rtl/cpu_low_power_mode_control.sv
module cpu_low_power_mode_control
  import lp_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       core_reset_low,
  input  wire logic       logic_power_ok,
  input  wire logic       ram_power_ok,
  input  wire logic [1:0] mode_request,
  input  wire logic       wfi_exec,
  input  wire logic       wfe_exec,
  input  wire logic       wake_event,
  input  wire logic       slave_busy,
  input  wire logic       coh_req_valid,
  input  wire logic       coh_req_coherent,
  input  wire logic       coh_cache_miss,
  input  wire logic       coh_cache_dirty,
  input  wire logic       dbg_req_valid,
  input  wire logic       dbg_core_reg,
  input  wire logic       dbg_no_clk_stop,
  output logic            wait_irq_pipe_halted_n,
  output logic            wait_evt_pipe_halted_n,
  output logic            core_clk_en,
  output logic            clk_stopped_n,
  output logic            ram_retain,
  output logic            coh_resp_valid,
  output logic            coherency_all_miss,
  output logic            coherency_dirty_hit,
  output logic            dbg_resp_valid,
  output logic            dbg_resp_error,
  output logic [7:0]      powerdown_reset_status,
  output logic [1:0]      cpu_mode
);
  pwr_mode_e    mode_reg;
  pwr_mode_e    mode_next;
  logic         by_wfi_reg;
  logic         rst_sync;
  logic         lpwr_sync;
  logic         rpwr_sync;
  logic         clk_run;
  logic         rst_seen_reg;
  logic [7:0]   status_next;
  logic         is_off;
  logic         is_standby;
  logic         wake_now;
  logic         svc_busy;
  logic         miss_next;
  logic         dirty_next;
  logic         dbg_err_next;
  logic         rst_asserted;
  logic         rst_released;

  // the reset pin and the power-good levels come from outside the controller's clock domain
  lp_sync #(.W(3)) u_sync
  (
    .clk    (clk),
    .resetn (resetn),
    .d      ({~core_reset_low, logic_power_ok, ram_power_ok}),
    .q      ({rst_sync, lpwr_sync, rpwr_sync})
  );

  assign is_off       = (mode_reg == MODE_DORMANT) || (mode_reg == MODE_SHUTDOWN);
  assign is_standby   = (mode_reg == MODE_STANDBY);
  assign wake_now     = wake_event;
  assign svc_busy     = coh_req_valid || dbg_req_valid || slave_busy || dbg_no_clk_stop;
  assign rst_asserted = rst_sync;
  assign rst_released = rst_seen_reg && !rst_sync;

  // power loss while in standby selects shutdown if ram power is also gone or shutdown is requested, else dormant
  always_comb
  begin
    mode_next = mode_reg;
    unique case (mode_reg)
      MODE_RUN:
        if (wfi_exec || wfe_exec)
          mode_next = MODE_STANDBY;
      MODE_STANDBY:
        if (!lpwr_sync)
          mode_next = (!rpwr_sync || mode_request == REQ_SHUTDOWN) ? MODE_SHUTDOWN : MODE_DORMANT;
        else if (wake_now || rst_asserted)
          mode_next = MODE_RUN;
      MODE_DORMANT:
        if (!rpwr_sync)
          mode_next = MODE_SHUTDOWN;
        else if (lpwr_sync && rst_released)
          mode_next = MODE_RUN;
      MODE_SHUTDOWN:
        if (lpwr_sync && rpwr_sync && rst_released)
          mode_next = MODE_RUN;
    endcase
  end

  // only a reset pulse seen after power returns counts as the exit
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      rst_seen_reg <= 1'b0;
    else if (!is_off || !lpwr_sync)
      rst_seen_reg <= 1'b0;
    else if (rst_sync)
      rst_seen_reg <= 1'b1;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      mode_reg   <= MODE_RUN;
      by_wfi_reg <= 1'b0;
    end
    else
    begin
      mode_reg <= mode_next;
      if (mode_reg == MODE_RUN && (wfi_exec || wfe_exec))
        by_wfi_reg <= wfi_exec;
    end
  end

  lp_clk_req u_clk
  (
    .clk     (clk),
    .resetn  (resetn),
    .standby (is_standby || is_off),
    .busy    (is_standby && svc_busy),
    .clk_run (clk_run)
  );

  // coherency and debug front ends sit in the always-on domain
  assign miss_next    = is_off ? 1'b1 : (coh_req_coherent ? coh_cache_miss : 1'b1);
  assign dirty_next   = (mode_reg == MODE_DORMANT) ? 1'b1 :
                        (mode_reg == MODE_SHUTDOWN) ? 1'b0 :
                        (coh_req_coherent && coh_cache_dirty);
  assign dbg_err_next = is_off && dbg_core_reg;

  // sticky bits: set wins over the read-clear from a status read
  assign status_next = {4'h0,
                        rst_sync | (powerdown_reset_status[ST_STICKY_RS] & ~(dbg_req_valid & ~dbg_core_reg)),
                        rst_sync,
                        is_off | (powerdown_reset_status[ST_STICKY_PD] & ~(dbg_req_valid & ~dbg_core_reg)),
                        is_off};

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wait_irq_pipe_halted_n <= 1'b1;
      wait_evt_pipe_halted_n <= 1'b1;
      core_clk_en            <= 1'b1;
      clk_stopped_n          <= 1'b1;
      ram_retain             <= 1'b1;
      coh_resp_valid         <= 1'b0;
      coherency_all_miss     <= 1'b0;
      coherency_dirty_hit    <= 1'b0;
      dbg_resp_valid         <= 1'b0;
      dbg_resp_error         <= 1'b0;
      powerdown_reset_status <= STATUS_RST;
      cpu_mode               <= 2'h0;
    end
    else
    begin
      wait_irq_pipe_halted_n <= !(mode_next == MODE_STANDBY && (mode_reg == MODE_RUN ? wfi_exec : by_wfi_reg));
      wait_evt_pipe_halted_n <= !(mode_next == MODE_STANDBY && (mode_reg == MODE_RUN ? !wfi_exec : !by_wfi_reg));
      core_clk_en            <= clk_run && !is_off;
      clk_stopped_n          <= clk_run && !is_off;
      ram_retain             <= (mode_next != MODE_SHUTDOWN);
      coh_resp_valid         <= coh_req_valid;
      coherency_all_miss     <= coh_req_valid && miss_next;
      coherency_dirty_hit    <= coh_req_valid && dirty_next;
      dbg_resp_valid         <= dbg_req_valid;
      dbg_resp_error         <= dbg_req_valid && dbg_err_next;
      powerdown_reset_status <= status_next;
      cpu_mode               <= mode_next;
    end
  end
endmodule

// ===== dv/lp_monitor.sv
module lp_monitor
  import lp_pkg::*;
(
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic       wfi_exec,
  input wire logic       coh_req_valid,
  input wire logic       dbg_req_valid,
  input wire logic       dbg_core_reg,
  input wire logic       wait_irq_pipe_halted_n,
  input wire logic       core_clk_en,
  input wire logic       ram_retain,
  input wire logic       coherency_all_miss,
  input wire logic       coherency_dirty_hit,
  input wire logic       dbg_resp_error,
  input wire logic [7:0] powerdown_reset_status,
  input wire logic [1:0] cpu_mode
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_dm; coh_req_valid && cpu_mode == 2 |=> coherency_all_miss && coherency_dirty_hit; endproperty
  a_dm: assert property (p_dm) else $error("dormant coh resp");
  property p_sd; coh_req_valid && cpu_mode == 3 |=> coherency_all_miss && !coherency_dirty_hit; endproperty
  a_sd: assert property (p_sd) else $error("shutdown coh resp");
  property p_de; dbg_req_valid && dbg_core_reg && cpu_mode[1] |=> dbg_resp_error; endproperty
  a_de: assert property (p_de) else $error("core dbg no error");
  property p_do; dbg_req_valid && !dbg_core_reg |=> !dbg_resp_error; endproperty
  a_do: assert property (p_do) else $error("domain dbg error");
  property p_wi; wfi_exec && cpu_mode == 0 |=> !wait_irq_pipe_halted_n && cpu_mode == 1; endproperty
  a_wi: assert property (p_wi) else $error("no halt flag");
  property p_rr; cpu_mode == 2 |-> ram_retain; endproperty
  a_rr: assert property (p_rr) else $error("rams dropped");
  property p_st; cpu_mode[1] && $past(cpu_mode[1]) |-> powerdown_reset_status[0]; endproperty
  a_st: assert property (p_st) else $error("no pd status");
  property p_ck; dbg_req_valid && dbg_core_reg && cpu_mode == 1 |-> ##[1:3] core_clk_en; endproperty
  a_ck: assert property (p_ck) else $error("clock stays off");
endmodule
bind cpu_low_power_mode_control lp_monitor u_mon (.*);

// ===== dv/lp_pwr_model.sv
module lp_pwr_model
  import lp_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       wait_irq_pipe_halted_n,
  input  wire logic       wait_evt_pipe_halted_n,
  input  wire logic [1:0] mode_request,
  input  wire logic       wake_event,
  input  wire logic       slave_busy,
  output logic            logic_power_ok,
  output logic            ram_power_ok,
  output logic            core_reset_low
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    {logic_power_ok, ram_power_ok, core_reset_low} = 3'h7;
    forever
    begin
      @(negedge clk);
      // power is cut only once halted and the slave port has drained; one cpu, so no sibling to order
      if (!(wait_irq_pipe_halted_n && wait_evt_pipe_halted_n) && mode_request[1] && !slave_busy)
      begin
        // reset falls with the supply so the logic never sits unpowered out of reset
        {logic_power_ok, core_reset_low} = 2'h0;
        ram_power_ok = mode_request != REQ_SHUTDOWN;
        // wake is sampled on the rising edge, the bench moves it on the falling one
        while (!wake_event) @(posedge clk);
        @(negedge clk);
        {logic_power_ok, ram_power_ok} = 2'h3;
        repeat (4) @(negedge clk);
        core_reset_low = 1'b1;
      end
    end
  end
endmodule

// ===== dv/cpu_low_power_mode_control_tb.sv
module cpu_low_power_mode_control_tb
  import lp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, resetn, wfi_exec, wfe_exec, wake_event, slave_busy, dbg_no_clk_stop, dbg_req_valid, dbg_core_reg;
  logic coh_req_valid, coh_req_coherent, coh_cache_miss, coh_cache_dirty, core_reset_low, logic_power_ok;
  logic ram_power_ok, wait_irq_pipe_halted_n, wait_evt_pipe_halted_n, core_clk_en, clk_stopped_n, ram_retain;
  logic coh_resp_valid, coherency_all_miss, coherency_dirty_hit, dbg_resp_valid, dbg_resp_error;
  logic [1:0] mode_request, cpu_mode;
  logic [7:0] powerdown_reset_status;
  int         n_errors, n_tests, seed, em;
  cpu_low_power_mode_control u_dut (.*);
  lp_pwr_model u_pwr (.*);
  task automatic give_verdict();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(logic [7:0] got, logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // expected response from the tracked mode em; standby keeps the cache live
  function automatic logic [2:0] ref_resp(logic c, logic [2:0] q);
    if (!c)
      return {1'b1, q[2] && em > 1, 1'b0};
    if (em > 1)
      return {2'h3, em == 2};
    return {1'b1, q[2] ? q[1:0] : 2'h2};
  endfunction
  task automatic req(logic c, logic [2:0] q);
    @(negedge clk);
    {coh_req_valid, dbg_req_valid, dbg_core_reg} = {c, !c, q[2]};
    {coh_req_coherent, coh_cache_miss, coh_cache_dirty} = q;
    @(negedge clk);
    {coh_req_valid, dbg_req_valid} = 2'h0;
    if (c)
      chk({coh_resp_valid, coherency_all_miss, coherency_dirty_hit}, ref_resp(c, q));
    else
      chk({dbg_resp_valid, dbg_resp_error, 1'b0}, ref_resp(c, q));
  endtask
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial
  begin
    #20000;
    n_errors++;
    give_verdict();
  end
  initial
  begin
    seed = 32'h8585;
    {resetn, wfi_exec, wfe_exec, wake_event, slave_busy, dbg_no_clk_stop} = 6'h0;
    {coh_req_valid, coh_req_coherent, coh_cache_miss, coh_cache_dirty, dbg_req_valid, dbg_core_reg} = 6'h0;
    mode_request = REQ_RUN;
    em = 0;
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    chk(powerdown_reset_status, STATUS_RST);
    for (int m = 1; m < 4; m++)
    begin
      mode_request = m[1] ? 2'(m) : REQ_RUN;
      repeat (3) req(1'b1, 3'($random(seed)));
      {wfi_exec, wfe_exec} = m[0] ? 2'h2 : 2'h1;
      @(negedge clk);
      {wfi_exec, wfe_exec} = 2'h0;
      em = 1;
      chk({wait_irq_pipe_halted_n, wait_evt_pipe_halted_n, cpu_mode}, {m[0] ? 2'h1 : 2'h2, 2'h1});
      repeat (6) @(negedge clk);
      em = m;
      chk({ram_retain, cpu_mode, powerdown_reset_status[0], core_clk_en, clk_stopped_n},
          {m != 3, 2'(m), m > 1, 2'h0});
      // each access starts from a gated clock, so coherent and debug restarts are seen apart
      for (int k = 0; k < 2; k++)
      begin
        req(!k[0], k[0] ? 3'h4 : 3'($random(seed)));
        @(negedge clk);
        chk({core_clk_en, clk_stopped_n}, {2{m == 1}});
        repeat (6) @(negedge clk);
        chk({core_clk_en, clk_stopped_n}, 8'h0);
      end
      {slave_busy, dbg_no_clk_stop} = {1'($random(seed)), 1'b1};
      repeat (2) @(negedge clk);
      chk({core_clk_en, clk_stopped_n}, {2{m == 1}});
      {slave_busy, dbg_no_clk_stop} = 2'h0;
      req(1'b0, 3'h0);
      wake_event = 1'b1;
      repeat (2) @(negedge clk);
      wake_event = 1'b0;
      repeat (m > 1 ? 12 : 1) @(negedge clk);
      em = 0;
      chk(cpu_mode, 8'(em));
      chk(powerdown_reset_status, 8'(int'(m > 1) << ST_STICKY_PD | int'(m > 1) << ST_STICKY_RS));
      req(1'b0, 3'h0);
      chk(powerdown_reset_status, STATUS_RST);
    end
    give_verdict();
  end
endmodule
